// ==== src/psa_top.sv ====
// Notes on behaviour
// - reverse or external: request0 is grant input
// - reverse or external: requests 5-2 are inputs
// - reverse or external: grant0 carries own request
// - reverse or external: grants 5-2 are outputs
// - arbiter grants by driving grant low
// - internal arbiter: parked idle bus drives address data parity
// - as master, assert 64-bit request
// - as target, 64-bit request is input
// - as target, drive 64-bit acknowledge low
// - as master, 64-bit acknowledge is input
// - forward: interrupts are synchronised inputs
// - reverse: interrupts are open-drain outputs
// - fanout clocks follow reference clock
// - bus logic timed by feedback clock
// - enable pin gates fanout clock outputs
// - strap low forward, high reverse
`timescale 1ns/10ps
`default_nettype none
module psa_top (
  input wire logic clk_in, // 250 MHz core clock
  input wire logic rst_n_in, // async reset, low active
  input wire psa_pkg::psa_bus_req_type bus_in, // register strobes
  output logic [psa_pkg::DATA_W-1:0] rd_data_out, // read data
  input wire logic reverse_bridging_strap_in, // mode strap
  input wire logic central_function_control_n_in, // arbiter strap
  input wire logic [psa_pkg::NUM_MASTERS-1:0] req_n_in, // request pins
  output logic [psa_pkg::NUM_MASTERS-1:0] gnt_n_out, // grant pins
  input wire logic bus_idle_in, // bus idle
  output logic park_drive_out, // drive AD, C/BE#, PAR
  output logic bridge_granted_out, // bridge may master
  input wire logic master_cycle_in, // bridge runs as master
  input wire logic target_cycle_in, // bridge is target
  input wire logic req64_n_in, // 64-bit request pin in
  output logic req64_n_out, // 64-bit request pin out
  output logic req64_n_oe_out, // 64-bit request enable
  input wire logic ack64_n_in, // 64-bit ack pin in
  output logic ack64_n_out, // 64-bit ack pin out
  output logic ack64_n_oe_out, // 64-bit ack enable
  output logic wide_transfer_out, // 64-bit width agreed
  input wire logic [psa_pkg::NUM_INT-1:0] int_n_in, // interrupt pins in
  output logic [psa_pkg::NUM_INT-1:0] int_n_out, // interrupt pins out
  output logic [psa_pkg::NUM_INT-1:0] int_n_oe_out, // interrupt enables
  output logic [psa_pkg::NUM_INT-1:0] int_req_out, // synced interrupts
  input wire logic reference_clock_in, // reference clock
  input wire logic m66en_in, // clock generator enable
  input wire logic feedback_clock_in, // feedback clock
  output logic [psa_pkg::NUM_FANOUT-1:0] fanout_clock_out, // fanout clocks
  output logic bus_clk_en_out // bus clock tick
);
  import psa_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_reg;
  wire logic rst_n = rst_sync_reg[1];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_reg <= RST_SYNC_RESET;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // ----------------------------------------
  // straps and mode
  // ----------------------------------------
  logic strap_done_reg;
  logic reverse_reg;
  logic cfn_high_reg;

  // straps are caught once after release; a later change is ignored
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_reg <= 1'b0;
      reverse_reg <= 1'b0;
      cfn_high_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      reverse_reg <= reverse_bridging_strap_in;
      cfn_high_reg <= central_function_control_n_in;
    end
  end

  wire logic ext_mode = reverse_reg | cfn_high_reg;

  // ----------------------------------------
  // clocking
  // ----------------------------------------
  logic fb_prev_reg;
  logic [NUM_FANOUT-1:0] fanout_reg;
  wire logic fanout_level = reference_clock_in & m66en_in;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fb_prev_reg <= 1'b0;
    end else begin
      fb_prev_reg <= feedback_clock_in;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FANOUT; gi++) begin : g_fanout
      always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
          fanout_reg[gi] <= 1'b0;
        end else begin
          fanout_reg[gi] <= fanout_level;
        end
      end
    end
  endgenerate

  // bus side advances on rising edges of the looped-back clock
  wire logic bus_clk_en = feedback_clock_in & ~fb_prev_reg;
  assign fanout_clock_out = fanout_reg;
  assign bus_clk_en_out = bus_clk_en;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  psa_ctrl_type ctrl_reg;
  logic [NUM_GP-1:0] gpo_reg;
  logic [DATA_W-1:0] rd_data_reg;
  psa_status_type status;
  wire logic sel_ctrl = (bus_in.addr == REG_CTRL_OFS);
  wire logic sel_gpo = (bus_in.addr == REG_GPO_OFS);
  wire logic sel_status = (bus_in.addr == REG_STATUS_OFS);
  wire logic [DATA_W-1:0] rd_mux =
    sel_ctrl ? DATA_W'(ctrl_reg) :
    sel_gpo ? DATA_W'(gpo_reg) :
    sel_status ? DATA_W'(status) : '0;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      gpo_reg <= GPO_RESET;
      rd_data_reg <= '0;
    end else begin
      if (bus_in.wr && sel_ctrl) begin
        ctrl_reg <= psa_ctrl_type'(bus_in.wdata[CTRL_W-1:0]);
      end
      if (bus_in.wr && sel_gpo) begin
        gpo_reg <= bus_in.wdata[NUM_GP-1:0];
      end
      // unmapped reads return zero; data stands for one cycle only
      rd_data_reg <= bus_in.rd ? rd_mux : '0;
    end
  end

  assign rd_data_out = rd_data_reg;

  // ----------------------------------------
  // arbitration and pin roles
  // ----------------------------------------
  logic [NUM_MASTERS-1:0] arb_grant;
  logic [OWNER_W-1:0] arb_owner;
  logic arb_owned;
  logic [NUM_MASTERS-1:0] gnt_n_reg;
  logic [NUM_GP-1:0] gpi_reg;
  logic ext_grant_reg;

  // request timing of the masters is trusted, no re-check here
  psa_rr_arbiter u_arb (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .bus_clk_en_in(bus_clk_en),
    .arb_enable_in(~ext_mode),
    .req_in(~req_n_in),
    .bus_idle_in(bus_idle_in),
    .grant_out(arb_grant),
    .owner_out(arb_owner),
    .owned_out(arb_owned)
  );

  wire logic [NUM_MASTERS-1:0] gnt_ext = {gpo_reg, 1'b1, ~ctrl_reg.bus_request};
  wire logic [NUM_MASTERS-1:0] gnt_pins = ext_mode ? gnt_ext : ~arb_grant;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gnt_n_reg <= GNT_IDLE;
      gpi_reg <= '0;
      ext_grant_reg <= 1'b0;
    end else begin
      gnt_n_reg <= gnt_pins;
      if (ext_mode) begin
        gpi_reg <= req_n_in[GP_LSB +: NUM_GP];
        ext_grant_reg <= ~req_n_in[0];
      end else begin
        gpi_reg <= '0;
        ext_grant_reg <= 1'b0;
      end
    end
  end

  assign gnt_n_out = gnt_n_reg;
  assign park_drive_out = ~ext_mode & ~arb_owned & bus_idle_in & (&gnt_n_reg);
  assign bridge_granted_out = ext_mode ? ext_grant_reg : ~arb_owned;

  // ----------------------------------------
  // 64-bit handshake
  // ----------------------------------------
  logic req64_oe_reg;
  logic ack64_oe_reg;
  logic wide_reg;
  wire logic as_master = master_cycle_in & ~target_cycle_in;
  wire logic as_target = target_cycle_in & ~master_cycle_in;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      req64_oe_reg <= 1'b0;
      ack64_oe_reg <= 1'b0;
      wide_reg <= 1'b0;
    end else begin
      req64_oe_reg <= as_master & ctrl_reg.req64_want;
      ack64_oe_reg <= as_target & ~req64_n_in & ctrl_reg.ack64_en;
      if (as_master) begin
        wide_reg <= ctrl_reg.req64_want & ~ack64_n_in;
      end else if (as_target) begin
        wide_reg <= ctrl_reg.ack64_en & ~req64_n_in;
      end else begin
        wide_reg <= 1'b0;
      end
    end
  end

  assign req64_n_out = 1'b0;
  assign req64_n_oe_out = req64_oe_reg;
  assign ack64_n_out = 1'b0;
  assign ack64_n_oe_out = ack64_oe_reg;
  assign wide_transfer_out = wide_reg;

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [NUM_INT-1:0] int_meta_reg;
  logic [NUM_INT-1:0] int_sync_reg;
  logic [NUM_INT-1:0] int_oe_reg;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      int_meta_reg <= '1;
      int_sync_reg <= '1;
      int_oe_reg <= '0;
    end else begin
      int_meta_reg <= int_n_in;
      int_sync_reg <= int_meta_reg;
      // software sets and clears the line; release is the driver's job
      int_oe_reg <= reverse_reg ? ctrl_reg.int_assert : '0;
    end
  end

  assign int_n_out = '0;
  assign int_n_oe_out = int_oe_reg;
  assign int_req_out = reverse_reg ? '0 : ~int_sync_reg;

  assign status = '{ext_mode: ext_mode, reverse: reverse_reg, owned: arb_owned,
                    owner: arb_owner, wide: wide_reg, ext_grant: ext_grant_reg,
                    int_req: int_req_out, general_purpose_input: gpi_reg};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  AST_GRANT_ONE: assert property (
    !ext_mode && $past(!ext_mode) |-> $onehot0(~gnt_n_out)) else $error("two grants");
  AST_GRANT_FOLLOW: assert property (
    !ext_mode && arb_owned |=> !gnt_n_out[$past(arb_owner)]) else $error("grant not driven");
  AST_EXT_GNT_IN: assert property (
    ext_mode |=> ext_grant_reg == !$past(req_n_in[0])) else $error("grant input lost");
  AST_GPI: assert property (
    ext_mode |=> gpi_reg == $past(req_n_in[5:2])) else $error("gpi wrong");
  AST_OWN_REQ: assert property (
    ext_mode && $past(ext_mode) |-> gnt_n_out[0] == !$past(ctrl_reg.bus_request))
    else $error("own request not on grant0");
  AST_GPO: assert property (
    ext_mode && $past(ext_mode) |-> gnt_n_out[5:2] == $past(gpo_reg)) else $error("gpo wrong");
  AST_PARK: assert property (
    !ext_mode && bus_idle_in && !arb_owned && $past(!arb_owned)
    |-> park_drive_out && (&gnt_n_out))
    else $error("bad park");
  AST_REQ64: assert property (
    as_master && ctrl_reg.req64_want |=> req64_n_oe_out && !req64_n_out)
    else $error("req64 not driven");
  AST_REQ64_IN: assert property (
    $past(target_cycle_in) |-> !req64_n_oe_out) else $error("req64 driven as target");
  AST_ACK64: assert property (
    as_target && !req64_n_in && ctrl_reg.ack64_en |=> ack64_n_oe_out && !ack64_n_out)
    else $error("ack64 not driven");
  AST_ACK64_IN: assert property (
    $past(master_cycle_in) |-> !ack64_n_oe_out) else $error("ack64 driven as master");
  AST_INT_SYNC: assert property (
    !reverse_reg && $past(!reverse_reg, 2) |-> int_req_out == ~$past(int_n_in, 2))
    else $error("interrupt sync latency");
  AST_INT_OUT: assert property (
    reverse_reg && $past(reverse_reg) |-> int_n_oe_out == $past(ctrl_reg.int_assert))
    else $error("interrupt drive wrong");
  AST_FANOUT: assert property (
    $past(rst_n) |-> fanout_clock_out == {NUM_FANOUT{$past(fanout_level)}})
    else $error("fanout clock wrong");
  AST_TICK: assert property (
    bus_clk_en_out |=> !bus_clk_en_out) else $error("tick longer than one cycle");

  COV_GRANT: cover property (!ext_mode && !gnt_n_out[3]);
  COV_PARK: cover property (park_drive_out ##1 !park_drive_out);
  COV_EXT_GRANT: cover property (ext_mode && ext_grant_reg);
  COV_WIDE: cover property (wide_transfer_out);
endmodule : psa_top
`default_nettype wire

// ==== src/psa_pkg.sv ====
// ----------------------------------------
// shared constants and types
// ----------------------------------------
package psa_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_MASTERS = 6;
  localparam int OWNER_W = 3;
  localparam int NUM_GP = 4;
  localparam int GP_LSB = 2;
  localparam int NUM_INT = 4;
  localparam int NUM_FANOUT = 7;
  localparam int CTRL_W = 7;
  localparam int STATUS_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_GPO_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 8'h08;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [NUM_GP-1:0] GPO_RESET = 4'h0;
  localparam logic [NUM_MASTERS-1:0] GNT_IDLE = 6'h3F;
  localparam logic [1:0] RST_SYNC_RESET = 2'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } psa_bus_req_type;

  typedef struct packed {
    logic [NUM_INT-1:0] int_assert;
    logic ack64_en;
    logic req64_want;
    logic bus_request;
  } psa_ctrl_type;

  typedef struct packed {
    logic ext_mode;
    logic reverse;
    logic owned;
    logic [OWNER_W-1:0] owner;
    logic wide;
    logic ext_grant;
    logic [NUM_INT-1:0] int_req;
    logic [NUM_GP-1:0] general_purpose_input;
  } psa_status_type;

  typedef enum logic [0:0] {
    PSA_ARB_PARK = 1'b0,
    PSA_ARB_OWNED = 1'b1
  } psa_arb_state_type;
endpackage : psa_pkg

// ==== src/psa_rr_arbiter.sv ====
`timescale 1ns/10ps
`default_nettype none
module psa_rr_arbiter (
  input wire logic clk_in, // core clock
  input wire logic rst_n_in, // synced reset
  input wire logic bus_clk_en_in, // bus clock tick
  input wire logic arb_enable_in, // internal arbiter mode
  input wire logic [psa_pkg::NUM_MASTERS-1:0] req_in, // requests, high active
  input wire logic bus_idle_in, // bus idle
  output logic [psa_pkg::NUM_MASTERS-1:0] grant_out, // one-hot grant
  output logic [psa_pkg::OWNER_W-1:0] owner_out, // granted index
  output logic owned_out // a master holds grant
);
  import psa_pkg::*;

  function automatic logic [NUM_MASTERS-1:0] onehot(input logic [OWNER_W-1:0] idx);
    onehot = NUM_MASTERS'(1) << idx;
  endfunction : onehot

  // nearest requester after last wins; last itself comes at the end
  function automatic logic [OWNER_W-1:0] rr_pick(input logic [NUM_MASTERS-1:0] req,
                                                 input logic [OWNER_W-1:0] last);
    logic [OWNER_W-1:0] idx;
    rr_pick = last;
    for (int k = NUM_MASTERS; k >= 1; k--) begin
      idx = OWNER_W'((int'(last) + k) % NUM_MASTERS);
      if (req[idx]) begin
        rr_pick = idx;
      end
    end
  endfunction : rr_pick

  psa_arb_state_type state_reg, state_next;
  logic [OWNER_W-1:0] owner_reg, owner_next;
  wire logic any_req = |req_in;
  wire logic [OWNER_W-1:0] pick = rr_pick(req_in, owner_reg);

  always_comb begin
    state_next = state_reg;
    owner_next = owner_reg;
    case (state_reg)
      PSA_ARB_PARK: begin
        if (arb_enable_in && any_req && bus_idle_in) begin
          state_next = PSA_ARB_OWNED;
          owner_next = pick;
        end
      end
      PSA_ARB_OWNED: begin
        if (!arb_enable_in) begin
          state_next = PSA_ARB_PARK;
        end else if (!req_in[owner_reg] && bus_idle_in) begin
          // rotate only once the owner lets go, so a burst is never cut
          state_next = any_req ? PSA_ARB_OWNED : PSA_ARB_PARK;
          owner_next = pick;
        end
      end
      default: begin
        state_next = PSA_ARB_PARK;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= PSA_ARB_PARK;
      owner_reg <= '0;
    end else if (bus_clk_en_in) begin
      state_reg <= state_next;
      owner_reg <= owner_next;
    end
  end

  assign owned_out = (state_reg == PSA_ARB_OWNED);
  assign owner_out = owner_reg;
  assign grant_out = owned_out ? onehot(owner_reg) : '0;

  AST_ARB_ONEHOT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $onehot0(grant_out)) else $error("more than one grant");
  AST_ARB_TICK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $changed(grant_out) |-> $past(bus_clk_en_in)) else $error("grant moved off tick");
  AST_ARB_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    owned_out && req_in[owner_reg] && arb_enable_in |=> $stable(owner_reg) && owned_out)
    else $error("grant lost while requested");
endmodule : psa_rr_arbiter
`default_nettype wire

// ==== sim/psa_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// far side: masters, interrupt sources, board clocks
// ----------------------------------------
module psa_far_model (
  input wire logic clk_in, // core clock
  input wire logic tick_in, // bus clock tick
  input wire logic raw_in, // pins follow want directly
  input wire logic [5:0] want_in, // masters wanting the bus
  input wire logic [3:0] int_src_in, // pending interrupt sources
  input wire logic [6:0] fanout_in, // fanout clocks
  output logic [5:0] req_n_out, // request pins
  output logic [3:0] int_n_out, // interrupt pins
  output logic ref_clk_out, // reference clock
  output logic fb_clk_out // feedback clock
);
  logic [5:0] req_n_reg;
  logic [1:0] gap_reg [6];
  logic [1:0] div_reg;
  initial begin
    req_n_reg = 6'h3F;
    div_reg = 2'h0;
    ref_clk_out = 1'b0;
    for (int i = 0; i < 6; i++) gap_reg[i] = 2'h2;
  end
  // reference clock at one eighth of the core rate
  always @(posedge clk_in) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) ref_clk_out <= ~ref_clk_out;
  end
  // a released request waits two bus clocks before coming back
  always @(posedge clk_in) begin
    if (tick_in) begin
      for (int i = 0; i < 6; i++) begin
        if (!req_n_reg[i] && !want_in[i]) begin
          req_n_reg[i] <= 1'b1;
          gap_reg[i] <= 2'h0;
        end else if (req_n_reg[i] && gap_reg[i] < 2'h2) begin
          gap_reg[i] <= gap_reg[i] + 2'h1;
        end else if (req_n_reg[i] && want_in[i]) begin
          req_n_reg[i] <= 1'b0;
        end
      end
    end
  end
  assign req_n_out = raw_in ? ~want_in : req_n_reg;
  // a source holds its line until the driver clears it there
  assign int_n_out = ~int_src_in;
  assign fb_clk_out = fanout_in[0];
endmodule : psa_far_model
`default_nettype wire

// ==== sim/psa_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module psa_top_tb;
  import psa_pkg::*;
  logic clk, rst_n, rev, cfn, idle, mc, tc, r64_in, a64_in, m66, raw, refc, fb, tick;
  logic r64_out, r64_oe, a64_out, a64_oe, wide, park, bgr;
  psa_bus_req_type bus;
  logic [DATA_W-1:0] rdat;
  logic [5:0] req_n, gnt_n, want;
  logic [3:0] int_n, int_out, int_oe, int_req, src;
  logic [6:0] fan;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  psa_top dut (.clk_in(clk), .rst_n_in(rst_n), .bus_in(bus), .rd_data_out(rdat),
    .reverse_bridging_strap_in(rev), .central_function_control_n_in(cfn),
    .req_n_in(req_n), .gnt_n_out(gnt_n), .bus_idle_in(idle), .park_drive_out(park),
    .bridge_granted_out(bgr), .master_cycle_in(mc), .target_cycle_in(tc),
    .req64_n_in(r64_in), .req64_n_out(r64_out), .req64_n_oe_out(r64_oe),
    .ack64_n_in(a64_in), .ack64_n_out(a64_out), .ack64_n_oe_out(a64_oe),
    .wide_transfer_out(wide), .int_n_in(int_n), .int_n_out(int_out),
    .int_n_oe_out(int_oe), .int_req_out(int_req), .reference_clock_in(refc),
    .m66en_in(m66), .feedback_clock_in(fb), .fanout_clock_out(fan),
    .bus_clk_en_out(tick));
  psa_far_model far (.clk_in(clk), .tick_in(tick), .raw_in(raw), .want_in(want),
    .int_src_in(src), .fanout_in(fan), .req_n_out(req_n), .int_n_out(int_n),
    .ref_clk_out(refc), .fb_clk_out(fb));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask : reg_wr
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge clk);
    bus <= '0;
    #1 d = rdat;
  endtask : reg_rd
  task automatic do_reset(input logic r, input logic c);
    @(posedge clk);
    rst_n <= 1'b0;
    rev <= r;
    cfn <= c;
    raw <= 1'b0;
    want <= 6'h00;
    repeat (2) @(posedge clk);
    chk(gnt_n, GNT_IDLE);
    chk(int_oe, 0);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : do_reset
  // waits for a grant pattern, watching that no two grants overlap
  task automatic wait_gnt(input logic [5:0] exp);
    for (int k = 0; k < 80 && gnt_n !== exp; k++) begin
      @(posedge clk);
      #1 chk($countones(~gnt_n) <= 1, 1);
    end
    chk(gnt_n, exp);
  endtask : wait_gnt
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_arbiter();
    logic [DATA_W-1:0] d;
    do_reset(1'b0, 1'b0);
    want <= 6'h08;
    wait_gnt(6'h37);
    chk(park, 0);
    reg_rd(REG_STATUS_OFS, d);
    chk(d[13:10], 4'hB);
    @(posedge clk);
    want <= 6'h22;
    wait_gnt(6'h1F);
    @(posedge clk);
    want <= 6'h02;
    wait_gnt(6'h3D);
    @(posedge clk);
    want <= 6'h00;
    wait_gnt(6'h3F);
    #1 chk(park, 1);
    chk(bgr, 1);
    @(posedge clk);
    idle <= 1'b0;
    @(posedge clk);
    #1 chk(park, 0);
    @(posedge clk);
    idle <= 1'b1;
  endtask : t_arbiter
  task automatic t_regs();
    logic [DATA_W-1:0] d;
    reg_rd(REG_CTRL_OFS, d);
    chk(d, 0);
    reg_rd(REG_GPO_OFS, d);
    chk(d, 0);
    reg_wr(REG_GPO_OFS, 32'h5);
    reg_wr(8'h10, 32'hF);
    reg_rd(REG_GPO_OFS, d);
    chk(d, 32'h5);
    @(posedge clk);
    #1 chk(rdat, 0);
    reg_rd(8'h10, d);
    chk(d, 0);
  endtask : t_regs
  task automatic t_wide();
    reg_wr(REG_CTRL_OFS, 32'h06);
    mc <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(r64_oe, 1);
    chk(a64_oe, 0);
    chk(r64_out, 0);
    @(posedge clk);
    a64_in <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(wide, 1);
    @(posedge clk);
    mc <= 1'b0;
    a64_in <= 1'b1;
    tc <= 1'b1;
    r64_in <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(r64_oe, 0);
    chk(a64_oe, 1);
    chk(a64_out, 0);
    @(posedge clk);
    tc <= 1'b0;
    r64_in <= 1'b1;
    reg_wr(REG_CTRL_OFS, 32'h00);
  endtask : t_wide
  task automatic t_ints();
    src <= 4'hA;
    repeat (3) @(posedge clk);
    #1 chk(int_req, 4'hA);
    chk(int_oe, 0);
    @(posedge clk);
    src <= 4'h0;
    repeat (3) @(posedge clk);
    #1 chk(int_req, 4'h0);
  endtask : t_ints
  task automatic t_clocks();
    logic r;
    int n;
    @(posedge clk);
    #1 r = refc;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      #1 chk(fan, {7{r}});
      r = refc;
    end
    @(posedge clk);
    m66 <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(fan, 0);
    @(posedge clk);
    m66 <= 1'b1;
    repeat (8) @(posedge clk);
    n = 0;
    for (int k = 0; k < 32; k++) begin
      @(posedge clk);
      #1 n += tick;
    end
    chk(n, 4);
  endtask : t_clocks
  task automatic t_modes();
    logic [DATA_W-1:0] d;
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0], !m[0]);
      raw <= 1'b1;
      want <= 6'h29;
      src <= 4'hF;
      repeat (4) @(posedge clk);
      #1 chk(bgr, 1);
      reg_rd(REG_STATUS_OFS, d);
      chk(d[3:0], 4'h5);
      chk(d[8], 1);
      chk(d[14], m);
      reg_wr(REG_CTRL_OFS, 32'h29);
      reg_wr(REG_GPO_OFS, 32'h6);
      repeat (2) @(posedge clk);
      #1 chk(gnt_n[0], 0);
      chk(gnt_n[5:2], 4'h6);
      chk(int_oe, m ? 4'h5 : 4'h0);
      chk(int_out, 0);
      if (m) chk(int_req, 0);
      @(posedge clk);
      src <= 4'h0;
    end
  endtask : t_modes
  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    bus = '0;
    rst_n = 1'b0;
    rev = 1'b0;
    cfn = 1'b0;
    idle = 1'b1;
    mc = 1'b0;
    tc = 1'b0;
    r64_in = 1'b1;
    a64_in = 1'b1;
    m66 = 1'b1;
    raw = 1'b0;
    want = 6'h00;
    src = 4'h0;
    t_arbiter();
    t_regs();
    t_wide();
    t_ints();
    t_clocks();
    t_modes();
    print_verdict();
  end
endmodule : psa_top_tb
`default_nettype wire
